// ---- rtl/cspp_pkg.sv ----
package cspp_pkg;
   // full 16-bit register byte addresses (even offsets); drain select printed at its own offset
   localparam logic [15:0] ADDR_B_DRAIN = 16'hf1d2;
   localparam logic [15:0] ADDR_B_DATA = 16'hf1d0;
   localparam logic [15:0] ADDR_B_DIR = 16'hf1d4;
   localparam logic [15:0] ADDR_A_DRAIN = 16'hf1e0;
   localparam logic [15:0] ADDR_A_LATCH = 16'hf1e2;
   localparam logic [15:0] ADDR_A_DIR = 16'hf1e4;
   localparam logic [15:0] ADDR_RESET_CFG = 16'hf1e6;
   localparam logic [15:0] ADDR_CTRL = 16'hf1e8;
   localparam logic [15:0] ADDR_IRQ_STATUS = 16'hf1ea;
   localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hf1ec;
   localparam logic [15:0] ADDR_IRQ_CLEAR = 16'hf1ee;
   localparam logic [15:0] ADDR_PIN_B = 16'hf1f0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // select count codes
   localparam logic [1:0] SEL_NONE = 2'b10;
   localparam logic [1:0] SEL_TWO = 2'b01;
   localparam logic [1:0] SEL_THREE = 2'b00;
   localparam logic [1:0] SEL_FIVE = 2'b11;
   // field positions
   localparam int COUNT_LSB = 1;
   localparam int CTRL_ARB_BIT = 0;
   localparam int CTRL_HOLD_BIT = 1;
   localparam int CTRL_PWM_LSB = 4;
   localparam int CTRL_CC_LSB = 8;
   localparam int CTRL_CCDIR_LSB = 12;
   // capture sampling period in cpu clocks
   localparam int SAMPLE_CYCLES = 8;
   localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_CYCLES - 1);
   typedef enum logic [1:0] {
      CSPP_RUN = 2'b00,
      CSPP_HOLD_KICK = 2'b01,
      CSPP_HOLD = 2'b10
   } cspp_hold_t;
endpackage

// ---- rtl/cspp_top.sv ----
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module cspp_top
   import cspp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [1:0] strap_count,
   input wire logic [4:0] window_select_n,
   input wire logic bus_want_req_n,
   input wire logic bus_takeover_grant_int_n,
   input wire logic [7:0] port_a_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   output logic [4:0] port_a_pullup,
   input wire logic [3:0] pwm_channel_pin,
   input wire logic [3:0] compare_out,
   input wire logic [3:0] compare_out_strobe,
   input wire logic [7:0] port_b_in,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic [3:0] capture_event,
   output logic hold_request,
   output logic irq
);
   logic [1:0] select_count_field;
   logic [1:0] strap_sync1;
   logic [1:0] strap_sync2;
   logic [7:0] next_a_out;
   logic [7:0] next_a_oe;
   logic [4:0] next_pullup;
   logic [7:0] next_b_out;
   logic [7:0] next_b_oe;
   logic [2:0] arb_level;
   localparam logic [2:0] ARB_DRIVE = 3'b110;
   logic [7:0] port_a_drain_select;
   logic [7:0] port_a_latch;
   logic [7:0] port_a_dir;
   logic [7:0] port_b_data;
   logic [7:0] port_b_direction;
   logic [7:0] port_b_drain_select;
   logic [15:0] ctrl;
   logic [7:0] a_sync1, a_sync2, b_sync1, b_sync2;
   logic [2:0] sample_cnt;
   logic [3:0] cap_prev;
   logic [3:0] next_capture;
   logic [3:0] irq_status, irq_enable;
   cspp_hold_t hold_state;
   logic [4:0] sel_mask;
   logic arbitration_enable;

   function automatic logic [4:0] count_mask(input logic [1:0] code);
      unique case (code)
         SEL_NONE: count_mask = 5'h00;
         SEL_TWO: count_mask = 5'h03;
         SEL_THREE: count_mask = 5'h07;
         SEL_FIVE: count_mask = 5'h1f;
      endcase
   endfunction

   // register hit: strobe high beside a matching address
   function automatic logic hit(input logic strobe, input logic [15:0] at,
                                input logic [15:0] reg_addr);
      hit = strobe && (at == reg_addr);
   endfunction

   // open drain: only a low is driven, a high floats
   function automatic logic gpio_level(input logic latch, input logic od);
      gpio_level = latch && !od;
   endfunction

   function automatic logic gpio_drive(input logic dir, input logic latch, input logic od);
      gpio_drive = dir && !(od && latch);
   endfunction

   assign sel_mask = count_mask(select_count_field);
   assign arbitration_enable = ctrl[CTRL_ARB_BIT];
   assign arb_level = {bus_want_req_n, bus_takeover_grant_int_n, 1'b0};

   // strap pins pass two flops before the count logic sees them
   always_ff @(posedge clk) begin
      strap_sync1 <= strap_count;
      strap_sync2 <= strap_sync1;
   end

   // count follows the strap through reset and freezes at release
   always_ff @(posedge clk) begin
      if (rst) begin
         select_count_field <= strap_sync2;
      end
   end

   always_ff @(posedge clk) begin
      a_sync1 <= port_a_in;
      a_sync2 <= a_sync1;
   end

   always_ff @(posedge clk) begin
      b_sync1 <= port_b_in;
      b_sync2 <= b_sync1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         port_a_drain_select <= RESET_BYTE;
      end else if (hit(wr, addr, ADDR_A_DRAIN)) begin
         port_a_drain_select <= wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         port_a_latch <= RESET_BYTE;
      end else if (hit(wr, addr, ADDR_A_LATCH)) begin
         port_a_latch <= wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         port_a_dir <= RESET_BYTE;
      end else if (hit(wr, addr, ADDR_A_DIR)) begin
         port_a_dir <= wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         port_b_direction <= RESET_BYTE;
      end else if (hit(wr, addr, ADDR_B_DIR)) begin
         port_b_direction <= wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         port_b_drain_select <= RESET_BYTE;
      end else if (hit(wr, addr, ADDR_B_DRAIN)) begin
         port_b_drain_select <= wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= RESET_WORD;
      end else if (hit(wr, addr, ADDR_CTRL)) begin
         ctrl <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_enable <= 4'h0;
      end else if (hit(wr, addr, ADDR_IRQ_ENABLE)) begin
         irq_enable <= wdata[3:0];
      end
   end

   // port B latch: lines 7..4 take compare output ahead of the latch
   always_ff @(posedge clk) begin
      if (rst) begin
         port_b_data <= RESET_BYTE;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (i >= 4 && compare_out_strobe[i-4]) begin
               port_b_data[i] <= compare_out[i-4];
            end else if (hit(wr, addr, ADDR_B_DATA)) begin
               port_b_data[i] <= wdata[i];
            end
         end
      end
   end

   // hold entry: drive selects high one cycle, then let the pull-up hold the selects not set open drain
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_state <= CSPP_RUN;
      end else begin
         unique case (hold_state)
            CSPP_RUN: if (ctrl[CTRL_HOLD_BIT]) hold_state <= CSPP_HOLD_KICK;
            CSPP_HOLD_KICK: hold_state <= CSPP_HOLD;
            CSPP_HOLD: if (!ctrl[CTRL_HOLD_BIT]) hold_state <= CSPP_RUN;
            default: hold_state <= CSPP_RUN;
         endcase
      end
   end

   // port A select lines; latch writes reach only the lines outside the select count
   for (genvar ga = 0; ga < 5; ga++) begin : g_sel
      logic gp_level;
      logic gp_drive;
      assign gp_level = gpio_level(port_a_latch[ga], port_a_drain_select[ga]);
      assign gp_drive = gpio_drive(port_a_dir[ga], port_a_latch[ga], port_a_drain_select[ga]);
      assign next_a_out[ga] = !sel_mask[ga] ? gp_level
                              : (hold_state == CSPP_RUN) ? window_select_n[ga]
                              : 1'b1;
      // hold drives the line high for one cycle, then lets it go
      assign next_a_oe[ga] = !sel_mask[ga] ? gp_drive
                             : (hold_state == CSPP_RUN)
                             ? !(port_a_drain_select[ga] && window_select_n[ga])
                             : (hold_state == CSPP_HOLD_KICK);
      assign next_pullup[ga] = sel_mask[ga] && (hold_state != CSPP_RUN)
                               && !port_a_drain_select[ga];
   end

   // port A arbitration lines
   for (genvar gr = 5; gr < 8; gr++) begin : g_arb
      assign next_a_out[gr] = arbitration_enable ? arb_level[gr-5]
                              : gpio_level(port_a_latch[gr], port_a_drain_select[gr]);
      assign next_a_oe[gr] = arbitration_enable ? ARB_DRIVE[gr-5]
                             : gpio_drive(port_a_dir[gr], port_a_latch[gr],
                                          port_a_drain_select[gr]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         port_a_out <= 8'h1f;
         port_a_oe <= 8'h00;
         port_a_pullup <= 5'h1f;
      end else begin
         port_a_out <= next_a_out;
         port_a_oe <= next_a_oe;
         port_a_pullup <= next_pullup;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hold_request <= 1'b0;
      end else begin
         hold_request <= arbitration_enable && !a_sync2[5];
      end
   end

   // port B pins
   for (genvar gb = 0; gb < 8; gb++) begin : g_port_b
      logic level;
      logic drive;
      if (gb < 4) begin : g_pwm
         assign level = port_b_data[gb]
                        ^ (ctrl[CTRL_PWM_LSB+gb] && pwm_channel_pin[gb]);
         assign drive = ctrl[CTRL_PWM_LSB+gb] || port_b_direction[gb];
      end else begin : g_capcom
         assign level = port_b_data[gb];
         assign drive = ctrl[CTRL_CC_LSB+gb-4] ? ctrl[CTRL_CCDIR_LSB+gb-4]
                        : port_b_direction[gb];
      end
      assign next_b_out[gb] = gpio_level(level, port_b_drain_select[gb]);
      assign next_b_oe[gb] = gpio_drive(drive, level, port_b_drain_select[gb]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         port_b_out <= RESET_BYTE;
         port_b_oe <= RESET_BYTE;
      end else begin
         port_b_out <= next_b_out;
         port_b_oe <= next_b_oe;
      end
   end

   // capture sampling period counter
   always_ff @(posedge clk) begin
      if (rst) begin
         sample_cnt <= 3'h0;
      end else begin
         sample_cnt <= (sample_cnt == SAMPLE_LAST) ? 3'h0 : sample_cnt + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cap_prev <= 4'h0;
         capture_event <= 4'h0;
      end else if (sample_cnt == SAMPLE_LAST) begin
         cap_prev <= b_sync2[7:4];
         capture_event <= next_capture;
      end else begin
         capture_event <= 4'h0;
      end
   end
   assign next_capture = (b_sync2[7:4] ^ cap_prev) & ctrl[CTRL_CC_LSB +: 4]
                         & ~ctrl[CTRL_CCDIR_LSB +: 4];

   // sticky status; set wins over clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= 4'h0;
      end else begin
         irq_status <= (irq_status & ~(hit(wr, addr, ADDR_IRQ_CLEAR) ? wdata[3:0] : 4'h0))
                       | capture_event;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= RESET_WORD;
      end else if (rd) begin
         unique case (addr)
            ADDR_A_DRAIN: rdata <= {8'h00, port_a_drain_select};
            ADDR_A_LATCH: rdata <= {8'h00, port_a_latch};
            ADDR_A_DIR: rdata <= {8'h00, port_a_dir};
            ADDR_B_DATA: rdata <= {8'h00, port_b_data};
            ADDR_B_DIR: rdata <= {8'h00, port_b_direction};
            ADDR_B_DRAIN: rdata <= {8'h00, port_b_drain_select};
            ADDR_RESET_CFG: rdata <= {13'h0000, select_count_field, 1'b0};
            ADDR_CTRL: rdata <= ctrl;
            ADDR_IRQ_STATUS: rdata <= {12'h000, irq_status};
            ADDR_IRQ_ENABLE: rdata <= {12'h000, irq_enable};
            ADDR_PIN_B: rdata <= {a_sync2, b_sync2};
            default: rdata <= RESET_WORD;
         endcase
      end else begin
         rdata <= RESET_WORD;
      end
   end
endmodule

// ---- verif/cspp_ext_model.sv ----
`timescale 1ns/10ps
module cspp_ext_model (
   input wire logic [7:0] a_out,
   input wire logic [7:0] a_oe,
   input wire logic [4:0] pull,
   input wire logic other_hold_n,
   output logic [7:0] a_pin
);
   logic [7:0] pl;
   assign pl = {3'b000, pull};
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (a_oe[i])
            a_pin[i] = a_out[i];
         else if (pl[i])
            a_pin[i] = 1'b1; // weak pull-up holds a released select
         else if (i == 5)
            a_pin[i] = other_hold_n; // other master asks for the bus
         else
            a_pin[i] = ~a_out[i]; // released line shows no stale level
      end
   end
endmodule

// ---- verif/cspp_monitor.sv ----
`timescale 1ns/10ps
module cspp_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic [4:0] window_select_n,
   input wire logic bus_want_req_n,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_oe,
   input wire logic [4:0] port_a_pullup,
   input wire logic [7:0] port_b_oe,
   input wire logic [3:0] capture_event,
   input wire logic hold_request,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // one sample every eight clocks leaves seven quiet cycles
   sequence quiet_seven;
      capture_event == 4'h0 [*7];
   endsequence
   AST_RST_PINS: assert property (@(posedge clk) disable iff (1'b0) rst |=>
      port_a_pullup == 5'h1f && port_a_oe == 8'h00 && port_b_oe == 8'h00 && !irq)
      else $error("pins not parked in reset");
   AST_RD_IDLE: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data without read");
   AST_ARB_DIR: assert property (hold_request |-> port_a_oe[7:5] == 3'b110)
      else $error("arbitration drivers wrong");
   AST_WANT_PIN: assert property (port_a_oe[7] && $past(port_a_oe[7]) |->
      port_a_out[7] == $past(bus_want_req_n)) else $error("bus request pin stale");
   AST_SEL_PIN: assert property (port_a_oe[0] && $past(port_a_oe[0]) |->
      port_a_out[0] == $past(window_select_n[0])) else $error("select pin stale");
   AST_PULL_OFF: assert property ((port_a_pullup & port_a_oe[4:0] & ~port_a_out[4:0]) == 5'h00)
      else $error("pull-up while driving");
   AST_CAP_RATE: assert property (capture_event != 4'h0 |=> quiet_seven)
      else $error("capture events too close");
   AST_CAP_IN: assert property (capture_event[3] |-> !port_b_oe[7])
      else $error("capture on driven line");
endmodule
bind cspp_top cspp_monitor mon_u (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
   .window_select_n(window_select_n), .bus_want_req_n(bus_want_req_n),
   .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_a_pullup(port_a_pullup),
   .port_b_oe(port_b_oe), .capture_event(capture_event), .hold_request(hold_request),
   .irq(irq));

// ---- verif/chip_select_and_pwm_port_pins_tb.sv ----
`timescale 1ns/10ps
module chip_select_and_pwm_port_pins_tb;
   import cspp_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, bw = 1, oth_n = 1, gnt = 1, hreq, irq;
   logic [15:0] addr = 0, wdata = 0, rdata, d;
   logic [1:0] strap = SEL_FIVE;
   logic [4:0] ws = 5'h1f, pull;
   logic [3:0] pwm = 0, cmp = 0, cstb = 0, cev;
   logic [7:0] a_in, a_out, a_oe, b_in = 0, b_out, b_oe;
   int err_count = 0, tests_run = 0, cyc = 0;
   always #10 clk = ~clk;
   cspp_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .strap_count(strap), .window_select_n(ws), .bus_want_req_n(bw),
      .bus_takeover_grant_int_n(gnt), .port_a_in(a_in), .port_a_out(a_out),
      .port_a_oe(a_oe), .port_a_pullup(pull), .pwm_channel_pin(pwm), .compare_out(cmp),
      .compare_out_strobe(cstb), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe),
      .capture_event(cev), .hold_request(hreq), .irq(irq));
   cspp_ext_model ext_u (.a_out(a_out), .a_oe(a_oe), .pull(pull), .other_hold_n(oth_n),
      .a_pin(a_in));
   task automatic close_out;
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         close_out;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wreg(input logic [15:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [15:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic t_count;
      logic [1:0] codes [4] = '{SEL_NONE, SEL_TWO, SEL_THREE, SEL_FIVE};
      logic [7:0] masks [4] = '{8'h00, 8'h03, 8'h07, 8'h1f};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         rst <= 1'b1;
         strap <= codes[i];
         tick(16);
         rst <= 1'b0;
         rreg(ADDR_RESET_CFG, d);
         chk(d[2:1], codes[i]);
         chk(a_oe, masks[i]);
      end
      wreg(ADDR_A_LATCH, 16'h0000);
      ws <= 5'h15;
      tick(3);
      chk(a_out[4:0], 5'h15);
      ws <= 5'h1f;
   endtask
   task automatic t_hold;
      wreg(ADDR_CTRL, 16'h0001);
      tick(2);
      chk(a_oe[7:5], 3'b110);
      bw <= 1'b0;
      oth_n <= 1'b0;
      gnt <= 1'b0;
      tick(6);
      chk(a_out[7], 1'b0);
      chk(a_out[6], 1'b0);
      chk(hreq, 1'b1);
      wreg(ADDR_A_DRAIN, 16'h0001);
      wreg(ADDR_CTRL, 16'h0003);
      tick(3);
      chk(a_oe[4:0], 5'h1f);
      chk(a_out[4:0], 5'h1f);
      tick(1);
      chk(a_oe[4:0], 5'h00);
      chk(pull, 5'h1e);
      bw <= 1'b1;
      oth_n <= 1'b1;
      gnt <= 1'b1;
      wreg(ADDR_CTRL, 16'h0000);
      wreg(ADDR_A_DRAIN, 16'h0000);
   endtask
   task automatic t_portb;
      rreg(ADDR_B_DRAIN, d);
      chk(d, 16'h0000);
      wreg(ADDR_B_DIR, 16'h00ff);
      wreg(ADDR_B_DATA, 16'h00a5);
      wreg(ADDR_CTRL, 16'h00f0);
      pwm <= 4'h3;
      tick(3);
      chk(b_out, 8'ha6);
      chk(b_oe, 8'hff);
      wreg(ADDR_B_DRAIN, 16'h000f);
      tick(2);
      chk(b_oe, 8'hf9);
      rreg(ADDR_B_DATA, d);
      chk(d[7:0], 8'ha5);
      wreg(ADDR_CTRL, 16'h1100);
      cmp <= 4'h1;
      cstb <= 4'h1;
      tick(1);
      cstb <= 4'h0;
      rreg(ADDR_B_DATA, d);
      chk(d[7:0], 8'hb5);
      wreg(ADDR_B_DIR, 16'h0000);
   endtask
   task automatic t_irq;
      int n = 0;
      wreg(ADDR_CTRL, 16'h0800);
      wreg(ADDR_IRQ_ENABLE, 16'h0008);
      b_in <= 8'h80;
      for (int i = 0; i < 24; i++) begin
         @(negedge clk);
         if (cev === 4'h8)
            n++;
      end
      chk(16'(n), 16'h0001);
      chk(irq, 1'b1);
      rreg(ADDR_IRQ_STATUS, d);
      chk(d[3], 1'b1);
      wreg(ADDR_IRQ_CLEAR, 16'h0008);
      wreg(ADDR_IRQ_ENABLE, 16'h0000);
      b_in <= 8'h00;
      tick(24);
      chk(irq, 1'b0);
      wreg(ADDR_IRQ_ENABLE, 16'h0008);
      tick(2);
      chk(irq, 1'b1);
      wreg(ADDR_IRQ_CLEAR, 16'h0008);
      tick(2);
      chk(irq, 1'b0);
      rreg(16'h0100, d);
      chk(d, 16'h0000);
   endtask
   initial begin
      t_count;
      t_hold;
      t_portb;
      t_irq;
      close_out;
   end
endmodule
